/* File: design/sci_pkg.sv */
// Shared constants for the serial control and baud-rate block
package sci_pkg;
    // ------------------------------------------------------------
    // Register byte offsets on the AHB-Lite bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_BAUD = 8'h0C;
    localparam logic [7:0] OFS_EXT_RX = 8'h10;
    localparam logic [7:0] OFS_EXT_TX = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_LIN_CTRL = 8'h1C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CA_RX9 = 7;
    localparam int CA_TX9 = 6;
    localparam int CA_PD = 5;
    localparam int CA_M = 4;
    localparam int CA_WAKE = 3;
    localparam int CA_PCE = 2;
    localparam int CA_PS = 1;
    localparam int CA_PIE = 0;
    localparam int CB_TIE = 7;
    localparam int CB_TX_DONE_IRQ_EN = 6;
    localparam int CB_RIE = 5;
    localparam int CB_IDLE_IRQ_EN = 4;
    localparam int CB_TE = 3;
    localparam int CB_RE = 2;
    localparam int CB_MUTE = 1;
    localparam int CB_SBK = 0;
    localparam int LC_LINE = 0;
    localparam int LC_HEADER_DETECT_SELECT = 1;
    localparam int LC_LPE = 2;

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_EXT = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'hC0;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] START_CENTER = 4'h7;
    localparam logic [3:0] PRE_DIV_0 = 4'h1;
    localparam logic [3:0] PRE_DIV_1 = 4'h3;
    localparam logic [3:0] PRE_DIV_2 = 4'h4;
    localparam logic [3:0] PRE_DIV_3 = 4'hD;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_WAIT = 3'b010,
        TX_SEND = 3'b100
    } sci_tx_state_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } sci_rx_state_t;
endpackage

/* File: design/sci_ctrl_baud.sv */
// Serial interface control, data and baud-rate registers with frame engines
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module sci_ctrl_baud (
    input wire logic clock,             // Bus clock, 25 MHz
    input wire logic rst_n,             // Synchronous reset, active low
    input wire logic hsel,              // AHB slave select
    input wire logic [31:0] haddr,      // AHB address
    input wire logic [1:0] htrans,      // AHB transfer type
    input wire logic hwrite,            // AHB write strobe
    input wire logic [2:0] hsize,       // AHB size, word only
    input wire logic [31:0] hwdata,     // AHB write data
    input wire logic hready,            // AHB bus ready
    output logic hreadyout,             // AHB slave ready
    output logic hresp,                 // AHB response, always OKAY
    output logic [31:0] hrdata,         // AHB read data
    input wire logic rx_pin,            // Serial receive line
    input wire logic lin_id_parity_err, // LIN identifier parity error pulse
    output logic tx_pin,                // Serial transmit line
    output logic irq                    // Interface interrupt request
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend, rd_pend;
    logic [7:0] bus_addr;
    logic [7:0] rd_mux;
    wire acc = hsel && htrans[1] && hready;
    wire [7:0] wdat = hwdata[7:0];
    wire wr_a = wr_pend && (bus_addr == sci_pkg::OFS_CTRL_A);
    wire wr_b = wr_pend && (bus_addr == sci_pkg::OFS_CTRL_B);
    wire wr_d = wr_pend && (bus_addr == sci_pkg::OFS_DATA);
    wire rd_d = rd_pend && (bus_addr == sci_pkg::OFS_DATA);
    wire rd_s = rd_pend && (bus_addr == sci_pkg::OFS_STATUS);

    // Reads take one wait state so a write just before is always seen
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            bus_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= acc && hwrite;
            rd_pend <= acc && !hwrite;
            if (acc) begin
                bus_addr <= haddr[7:0];
            end
            hreadyout <= !(acc && !hwrite);
            hresp <= 1'b0;
            if (rd_pend) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [6:0] ctrl_a;
    logic [7:0] ctrl_b, baud, ext_rx, ext_tx, tx_hold, rx_hold;
    logic [2:0] lin_ctrl;
    logic rx_ninth, tbe, tcf, rxf, quiet, ovr, ferr, pfault, stat_seen;
    wire m9 = ctrl_a[sci_pkg::CA_M];
    wire parity_enable = ctrl_a[sci_pkg::CA_PCE];
    wire line = lin_ctrl[sci_pkg::LC_LINE];
    wire amk = line ? lin_ctrl[sci_pkg::LC_HEADER_DETECT_SELECT] : ctrl_a[sci_pkg::CA_WAKE];
    wire [7:0] status = {tbe, tcf, rxf, quiet, ovr, 1'b0, ferr, pfault};

    // Read selection; undecoded offsets read zero
    assign rd_mux = (bus_addr == sci_pkg::OFS_CTRL_A) ? {rx_ninth, ctrl_a} :
                    (bus_addr == sci_pkg::OFS_CTRL_B) ? ctrl_b :
                    (bus_addr == sci_pkg::OFS_DATA) ? rx_hold :
                    (bus_addr == sci_pkg::OFS_BAUD) ? baud :
                    (bus_addr == sci_pkg::OFS_EXT_RX) ? ext_rx :
                    (bus_addr == sci_pkg::OFS_EXT_TX) ? ext_tx :
                    (bus_addr == sci_pkg::OFS_STATUS) ? status :
                    (bus_addr == sci_pkg::OFS_LIN_CTRL) ? {5'h00, lin_ctrl} : 8'h00;

    // Plain configuration registers and the transmit holding register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_a <= sci_pkg::RST_CTRL[6:0];
            baud <= sci_pkg::RST_BAUD;
            ext_rx <= sci_pkg::RST_EXT;
            ext_tx <= sci_pkg::RST_EXT;
            lin_ctrl <= 3'h0;
            tx_hold <= 8'h00;
        end else begin
            if (wr_a) ctrl_a <= wdat[6:0];
            if (wr_pend && bus_addr == sci_pkg::OFS_BAUD) baud <= wdat;
            if (wr_pend && bus_addr == sci_pkg::OFS_EXT_RX) ext_rx <= wdat;
            if (wr_pend && bus_addr == sci_pkg::OFS_EXT_TX) ext_tx <= wdat;
            if (wr_pend && bus_addr == sci_pkg::OFS_LIN_CTRL) lin_ctrl <= wdat[2:0];
            if (wr_d) tx_hold <= wdat;
        end
    end

    // ------------------------------------------------------------
    // Baud generation: prescaler, stage divider, extended divider
    // ------------------------------------------------------------
    sci_pkg::sci_tx_state_t tx_st;
    sci_pkg::sci_rx_state_t rx_st;
    logic [3:0] pre_cnt;
    logic [3:0] pre_max;
    // Power-down waits for both engines to finish their frame
    wire pd_stop = ctrl_a[sci_pkg::CA_PD] && (tx_st != sci_pkg::TX_SEND) &&
                   (rx_st == sci_pkg::RX_HUNT);
    assign pre_max = (baud[7:6] == 2'b00) ? sci_pkg::PRE_DIV_0 - 4'h1 :
                     (baud[7:6] == 2'b01) ? sci_pkg::PRE_DIV_1 - 4'h1 :
                     (baud[7:6] == 2'b10) ? sci_pkg::PRE_DIV_2 - 4'h1 :
                     sci_pkg::PRE_DIV_3 - 4'h1;
    wire pre_tick = !pd_stop && (pre_cnt == pre_max);

    // First prescaler
    always_ff @(posedge clock) begin
        if (!rst_n || pd_stop || pre_tick) pre_cnt <= 4'h0;
        else pre_cnt <= pre_cnt + 4'h1;
    end

    // Channel 0 is receive, channel 1 is transmit; each gives 16 ticks per bit
    logic [1:0] os_tick;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [6:0] stg_cnt;
            logic [7:0] ext_cnt;
            wire [2:0] code = (ch == 0) ? baud[2:0] : baud[5:3];
            wire [7:0] ext = (ch == 0) ? ext_rx : ext_tx;
            wire [6:0] stg_max = 7'((8'h01 << code) - 8'h01);
            wire stg_tick = pre_tick && (stg_cnt == stg_max);
            wire ext_hit = (ext == 8'h00) || (ext_cnt == ext - 8'h01);
            assign os_tick[ch] = stg_tick && ext_hit;
            always_ff @(posedge clock) begin
                if (!rst_n) stg_cnt <= 7'h00;
                else if (pre_tick) stg_cnt <= stg_tick ? 7'h00 : stg_cnt + 7'h01;
            end
            // Extended divider sits behind the conventional one
            always_ff @(posedge clock) begin
                if (!rst_n || ext == 8'h00) ext_cnt <= 8'h00;
                else if (stg_tick) ext_cnt <= ext_hit ? 8'h00 : ext_cnt + 8'h01;
            end
        end
    endgenerate
    wire rx_tick = os_tick[0];
    wire tx_tick = os_tick[1];

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [3:0] tx_sub, tx_left;
    logic [11:0] tx_sh;
    logic tx_data_frame, te_prev, sbk_prev, te_off_seen, pre_pend, brk_pend;
    wire te = ctrl_b[sci_pkg::CB_TE];
    wire bit_end = tx_tick && (tx_sub == sci_pkg::OVERSAMPLE_LAST);
    wire [3:0] nbits = m9 ? 4'hB : 4'hA;
    wire [8:0] d9 = {ctrl_a[sci_pkg::CA_TX9], tx_hold};
    wire gen_par = parity_enable && !line;
    wire par_bit = (m9 ? ^d9[7:0] : ^d9[6:0]) ^ ctrl_a[sci_pkg::CA_PS];
    wire [8:0] d9p = !gen_par ? d9 :
                     m9 ? {par_bit, d9[7:0]} : {d9[8], par_bit, d9[6:0]};
    wire tx_go = (tx_st == sci_pkg::TX_IDLE) && te && te_prev && !ctrl_a[sci_pkg::CA_PD];
    wire load_brk = tx_go && brk_pend;
    wire load_pre = tx_go && !brk_pend && pre_pend;
    wire load_dat = tx_go && !brk_pend && !pre_pend && !tbe;
    wire tx_last = (tx_st == sci_pkg::TX_SEND) && bit_end && (tx_left == 4'h1);

    // Frame engine; parity mode and format are frozen into the frame at load
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_st <= sci_pkg::TX_IDLE;
            tx_sub <= 4'h0;
            tx_left <= 4'h0;
            tx_sh <= 12'hFFF;
            tx_data_frame <= 1'b0;
        end else begin
            tx_sub <= tx_tick ? tx_sub + 4'h1 : tx_sub;
            case (tx_st)
                sci_pkg::TX_IDLE: begin
                    tx_sub <= 4'h0;
                    if (te && !te_prev) begin
                        tx_st <= sci_pkg::TX_WAIT;
                    end else if (load_brk || load_pre || load_dat) begin
                        tx_st <= sci_pkg::TX_SEND;
                        tx_left <= load_brk ? nbits + 4'h1 : nbits;
                        tx_data_frame <= load_dat;
                        tx_sh <= load_brk ? 12'(12'h001 << nbits) :
                                 load_pre ? 12'hFFF :
                                 m9 ? {2'b11, d9p, 1'b0} : {3'b111, d9p[7:0], 1'b0};
                    end
                end
                sci_pkg::TX_WAIT: begin
                    if (bit_end) tx_st <= sci_pkg::TX_IDLE;
                end
                sci_pkg::TX_SEND: begin
                    if (bit_end) begin
                        tx_sh <= {1'b1, tx_sh[11:1]};
                        tx_left <= tx_left - 4'h1;
                    end
                    if (tx_last) tx_st <= sci_pkg::TX_IDLE;
                end
                default: tx_st <= sci_pkg::TX_IDLE;
            endcase
        end
    end

    // Line driver idles high, also while powered down
    always_ff @(posedge clock) begin
        if (!rst_n) tx_pin <= 1'b1;
        else tx_pin <= (tx_st == sci_pkg::TX_SEND) ? tx_sh[0] : 1'b1;
    end

    // Preamble and break requests; a new request wins over the load that clears it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            te_prev <= 1'b0;
            sbk_prev <= 1'b0;
            te_off_seen <= 1'b0;
            pre_pend <= 1'b0;
            brk_pend <= 1'b0;
        end else begin
            te_prev <= te;
            sbk_prev <= ctrl_b[sci_pkg::CB_SBK];
            if (!te && te_prev && tx_st == sci_pkg::TX_SEND) te_off_seen <= 1'b1;
            else if (te && !te_prev) te_off_seen <= 1'b0;
            if (te && !te_prev && te_off_seen) pre_pend <= 1'b1;
            else if (load_pre) pre_pend <= 1'b0;
            if (!ctrl_b[sci_pkg::CB_SBK] && sbk_prev) brk_pend <= 1'b1;
            else if (load_brk) brk_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic rx_s1, rx_s2, rx_s3, rx_line;
    logic [3:0] rx_sub, rx_cnt;
    logic [9:0] rx_sh;
    logic [7:0] quiet_cnt;
    logic idle_armed;
    wire mute = ctrl_b[sci_pkg::CB_MUTE];
    wire [8:0] rd9 = m9 ? rx_sh[8:0] : {1'b0, rx_sh[8:1]};
    wire rx_msb = m9 ? rd9[8] : rd9[7];
    wire rx_end = (rx_st == sci_pkg::RX_DATA) && rx_tick &&
                  (rx_sub == sci_pkg::OVERSAMPLE_LAST) && (rx_cnt == nbits - 4'h2);
    logic rx_done;
    wire addr_wake = rx_done && mute && amk && rx_msb;
    wire accept = rx_done && (!mute || addr_wake);
    wire quiet_hit = (quiet_cnt == {nbits, 4'h0});
    wire idle_evt = quiet_hit && rx_tick && idle_armed && ctrl_b[sci_pkg::CB_RE];
    wire idle_wake = idle_evt && mute && !amk;
    wire byte_perr = parity_enable && !line && (m9 ? ^rd9 : ^rd9[7:0]) != ctrl_a[sci_pkg::CA_PS];

    // Three-stage input sync; a level counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_line <= 1'b1;
        end else begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) rx_line <= rx_s3;
        end
    end

    // Start hunt, start confirm at mid-bit, then one sample per bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_st <= sci_pkg::RX_HUNT;
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 10'h000;
            rx_done <= 1'b0;
        end else begin
            rx_done <= rx_end;
            if (rx_tick) rx_sub <= rx_sub + 4'h1;
            case (rx_st)
                sci_pkg::RX_HUNT: begin
                    rx_sub <= 4'h0;
                    if (ctrl_b[sci_pkg::CB_RE] && !rx_line && rx_tick) begin
                        rx_st <= sci_pkg::RX_START;
                    end
                end
                sci_pkg::RX_START: begin
                    if (rx_tick && rx_sub == sci_pkg::START_CENTER) begin
                        rx_st <= rx_line ? sci_pkg::RX_HUNT : sci_pkg::RX_DATA;
                        rx_sub <= 4'h0;
                        rx_cnt <= 4'h0;
                    end
                end
                sci_pkg::RX_DATA: begin
                    if (rx_tick && rx_sub == sci_pkg::OVERSAMPLE_LAST) begin
                        rx_sh <= {rx_line, rx_sh[9:1]};
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_end) rx_st <= sci_pkg::RX_HUNT;
                    end
                end
                default: rx_st <= sci_pkg::RX_HUNT;
            endcase
        end
    end

    // Idle detector: a frame time of high line after a received byte
    always_ff @(posedge clock) begin
        if (!rst_n || !rx_line || rx_st != sci_pkg::RX_HUNT) quiet_cnt <= 8'h00;
        else if (rx_tick && !quiet_hit) quiet_cnt <= quiet_cnt + 8'h01;
    end

    // Receive holding register is kept on overrun; the shifter is lost
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_hold <= 8'h00;
            rx_ninth <= 1'b0;
            idle_armed <= 1'b0;
        end else begin
            if (accept && !rxf) begin
                rx_hold <= rd9[7:0];
                rx_ninth <= m9 ? rd9[8] : rx_ninth;
            end
            if (accept && !rxf) idle_armed <= 1'b1;
            else if (idle_evt) idle_armed <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register B with hardware wake clear
    // ------------------------------------------------------------
    wire mute_locked = amk && rxf;
    wire [7:0] cb_wr = {wdat[7:2], mute_locked ? mute : wdat[1], wdat[0]};
    always_ff @(posedge clock) begin
        if (!rst_n) ctrl_b <= sci_pkg::RST_CTRL;
        else if (addr_wake || idle_wake) ctrl_b <= {ctrl_b[7:2], 1'b0, ctrl_b[0]};
        else if (wr_b) ctrl_b <= cb_wr;
    end

    // ------------------------------------------------------------
    // Status flags: status read then data access clears, any data write alone clears tbe; a set wins
    // ------------------------------------------------------------
    wire clr_rx = rd_d && stat_seen;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {tbe, tcf, rxf, quiet, ovr} <= sci_pkg::RST_STATUS[7:3];
            ferr <= 1'b0;
            pfault <= 1'b0;
            stat_seen <= 1'b0;
        end else begin
            if (rd_s) stat_seen <= 1'b1;
            else if (rd_d || wr_d) stat_seen <= 1'b0;
            tbe <= load_dat || (tbe && !wr_d);
            tcf <= (tx_last && tx_data_frame && tbe) || (tcf && !(wr_d && stat_seen));
            rxf <= (accept && !rxf) || (rxf && !clr_rx);
            ovr <= (accept && rxf) || (ovr && !clr_rx);
            quiet <= (idle_evt && !mute) || (quiet && !clr_rx);
            ferr <= (accept && !rxf && !rx_sh[9]) || (ferr && !clr_rx);
            pfault <= (accept && !rxf && byte_perr) ||
                      (parity_enable && line && lin_ctrl[sci_pkg::LC_LPE] && lin_id_parity_err) ||
                      (pfault && !clr_rx);
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) irq <= 1'b0;
        else irq <= (ctrl_b[sci_pkg::CB_TIE] && tbe) ||
                    (ctrl_b[sci_pkg::CB_TX_DONE_IRQ_EN] && tcf) ||
                    (ctrl_b[sci_pkg::CB_RIE] && (ovr || rxf)) ||
                    (ctrl_b[sci_pkg::CB_IDLE_IRQ_EN] && quiet) ||
                    (ctrl_a[sci_pkg::CA_PIE] && pfault);
    end
endmodule // sci_ctrl_baud

`default_nettype wire

/* File: sim/sci_node.sv */
// Behavioural remote serial node facing the block's serial lines
`timescale 1ns/1ns
`default_nettype none
module sci_node (
    input wire logic clock, // Bus clock, used as bit-time ruler
    input wire logic tx_pin, // Line driven by the block
    output var logic rx_pin // Line into the block, idles high
);
    // ----------------------------------------
    // Frame tasks, bit time given per call
    // ----------------------------------------
    initial rx_pin = 1'h1;
    // Start low, eight bits LSB first, stop high
    task automatic send(input logic [7:0] v, input int bc);
        logic [9:0] f;
        f = {1'h1, v, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (bc) @(posedge clock);
        end
    endtask
    // Sample at mid-bit; unknown result flags a lost or broken frame
    task automatic recv(output logic [8:0] v, input int bc, input int nb);
        int n;
        v = 9'h000;
        n = 0;
        while (tx_pin !== 1'h0 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        repeat (bc / 2) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge clock);
            v[i] = tx_pin;
        end
        repeat (bc) @(posedge clock);
        if (n >= 20000 || tx_pin !== 1'h1) v = 9'hxxx;
        repeat (bc / 2) @(posedge clock);
    endtask
endmodule // sci_node
`default_nettype wire

/* File: sim/sci_ctrl_baud_properties.sv */
// Concurrent checks on the serial block's bus and line ports
`timescale 1ns/1ns
`default_nettype none
module sci_props (
    input wire logic clock, // Bus clock
    input wire logic rst_n, // Reset, low
    input wire logic hsel, // Select
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic [31:0] hrdata, // Read data
    input wire logic tx_pin, // Serial out
    input wire logic irq // Interrupt
);
    // ----------------------------------------
    // Bus and line relations
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire take = hsel && htrans[1] && hready; // Transfer accepted
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("response not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
        else $error("read data moved");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_irq_reset: assert property ($rose(rst_n) |-> !irq)
        else $error("irq after reset");
    a_tx_idle: assert property ($rose(rst_n) |-> tx_pin)
        else $error("line not idle");
    a_start_width: assert property ($fell(tx_pin) |-> !tx_pin [*8] ##1 !tx_pin [*8])
        else $error("start bit short");
endmodule // sci_props
bind sci_ctrl_baud sci_props u_props (.clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_pin(tx_pin), .irq(irq));
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the serial control and baud-rate block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb;
    logic clock, hreadyout, hresp, tx_pin, irq, rx_pin;
    logic rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, lin_err = 1'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, seed;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] b;
    logic [8:0] r, e, q[$];
    int num_errors, tests_run;
    logic [7:0] ofs[8] = '{sci_pkg::OFS_CTRL_A, sci_pkg::OFS_CTRL_B, sci_pkg::OFS_BAUD,
        sci_pkg::OFS_EXT_RX, sci_pkg::OFS_EXT_TX, sci_pkg::OFS_STATUS, 8'h40, sci_pkg::OFS_DATA};
    logic [7:0] bt[6] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h08, 8'h00};
    logic [7:0] et[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [7:0] ca[6] = '{8'h00, 8'h00, 8'h06, 8'h04, 8'h00, 8'h50};
    int bc[6] = '{16, 48, 64, 208, 96, 16};
    wire hready = hreadyout;
    sci_ctrl_baud dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rx_pin(rx_pin), .lin_id_parity_err(lin_err),
        .tx_pin(tx_pin), .irq(irq));
    sci_node node (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin));
    // ----------------------------------------
    // Clock, random source, bus master, verdict
    // ----------------------------------------
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Single word transfer; ready is awaited in both phases, never assumed
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd,
        output logic [7:0] rd);
        int n;
        n = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'h1 && ++n < 100);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        do @(posedge clock); while (hready !== 1'h1 && ++n < 100);
        rd = hrdata[7:0];
        if (n >= 100) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // Main sequence: reset values, random access, frames out, frames in
    initial begin
        seed = 32'h0000_2082;
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            bus(ofs[i], 1'h0, 8'h00, b);
            `CHK(b, i == 5 ? 8'hC0 : 8'h00)
        end
        repeat (4) for (int k = 0; k < 7; k++) begin
            seed = lfsr(seed);
            if (k == 1 || k == 5) continue;
            bus(ofs[k], 1'h1, seed[7:0], b);
            bus(ofs[k], 1'h0, 8'h00, b);
            `CHK(b, k == 6 ? 8'h00 : k == 0 ? seed[7:0] & 8'h7F : seed[7:0])
        end
        // Format is changed only between frames, never during one
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            bus(ofs[2], 1'h1, bt[i], b);
            bus(ofs[4], 1'h1, et[i], b);
            bus(ofs[0], 1'h1, ca[i], b);
            bus(ofs[1], 1'h1, 8'h08, b);
            bus(ofs[7], 1'h1, seed[7:0], b);
            e = ca[i][4] ? {ca[i][6], seed[7:0]} :
                {1'h0, ca[i][2] ? ^seed[6:0] ^ ca[i][1] : seed[7], seed[6:0]};
            q.push_back(e);
            node.recv(r, bc[i], ca[i][4] ? 9 : 8);
            `CHK(r, q.pop_front())
            if ($isunknown(r)) give_verdict();
        end
        bus(ofs[2], 1'h1, 8'h00, b);
        bus(ofs[3], 1'h1, 8'h00, b);
        bus(ofs[0], 1'h1, 8'h00, b);
        bus(ofs[1], 1'h1, 8'h20, b);
        node.send(8'h5A, 16);
        repeat (40) @(posedge clock);
        bus(ofs[5], 1'h0, 8'h00, b);
        `CHK(b[5], 1'h0)
        bus(ofs[1], 1'h1, 8'h24, b);
        seed = lfsr(seed);
        node.send(seed[7:0], 16);
        repeat (40) @(posedge clock);
        `CHK(irq, 1'h1)
        bus(ofs[5], 1'h0, 8'h00, b);
        bus(ofs[7], 1'h0, 8'h00, b);
        `CHK(b, seed[7:0])
        repeat (2) @(posedge clock);
        `CHK(irq, 1'h0)
        // Mute only after a byte came in, else idle-line wake never fires
        bus(ofs[1], 1'h1, 8'h86, b);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'h1)
        repeat (150) @(posedge clock);
        bus(ofs[1], 1'h0, 8'h00, b);
        `CHK(b, 8'h84)
        // LIN identifier parity error reaches the flag and the interrupt
        bus(ofs[1], 1'h1, 8'h00, b);
        bus(sci_pkg::OFS_LIN_CTRL, 1'h1, 8'h05, b);
        bus(ofs[0], 1'h1, 8'h05, b);
        `CHK(irq, 1'h0)
        lin_err <= 1'h1;
        @(posedge clock);
        lin_err <= 1'h0;
        repeat (2) @(posedge clock);
        `CHK(irq, 1'h1)
        bus(ofs[5], 1'h0, 8'h00, b);
        `CHK(b[0], 1'h1)
        give_verdict();
    end
endmodule // tb
`default_nettype wire
